/* hw/sch_cmd_handler.sv */
// Command handler for pin toggle, port, multicast and factory-restore commands.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Toggle command inverts named output pin.
// - Toggle needs GPIO output; else 8/22.
// - Success code only sent when acks enabled.
// - Too few args code 1; too many 2.
// - UART: config byte, then 3-byte baud LSB-first.
// - UART disabled: baud bytes may be omitted.
// - Enable bit zero disables, one enables.
// - Parity field: 0 none, 2 even, 3 odd.
// - Stop bit: 0 one, 1 two.
// - Flow bit: 0 off, 1 on.
// - UART pin busy: code 9 plus pin.
// - SPI: config byte then pending pin.
// - CPOL sets idle clock level.
// - CPHA picks first or second edge.
// - Restore needs key, else code 7.
// - Valid restore: defaults, reset, no ack.
// - After restore: report 3, then net-up.
// - Multicast: 2-byte count, 1-byte field count.
// - Groups numbered from 1; a group count of 0 is accepted.
// - One byte per 8 groups; else code 5.
// - Too many groups 10; bad fields 11.
module sch_cmd_handler
  import sch_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_id,
  input wire logic arg_vld,
  input wire logic [7:0] arg_byte,
  input wire logic cmd_end,
  input wire logic ack_en,
  input wire logic [NPIN-1:0] pin_is_gpio,
  input wire logic [NPIN-1:0] pin_is_out,
  input wire logic [NPIN-1:0] pin_busy,
  input wire logic [7:0] uart_a_pin,
  input wire logic [7:0] uart_b_pin,
  input wire logic [15:0] mem_free_bytes,
  input wire logic net_ready,
  output logic busy,
  output logic rsp_vld,
  output logic [7:0] rsp_code,
  output logic rsp_has_pin,
  output logic [7:0] rsp_pin,
  output logic net_up_msg,
  output logic soft_rst,
  output logic [NPIN-1:0] gpio_out,
  output logic [7:0] uart_a_cfg,
  output logic [23:0] uart_a_baud,
  output logic [7:0] uart_b_cfg,
  output logic [23:0] uart_b_baud,
  output logic [7:0] spi_cfg,
  output logic [7:0] spi_pend_pin,
  output logic [15:0] grp_count,
  output logic [7:0] grp_fields,
  output logic [15:0] grp_mem_bytes
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_COLLECT = 4'b0010,
    ST_RESET = 4'b0100,
    ST_WAIT_NET = 4'b1000
  } sch_st_t;

  typedef struct packed {
    sch_st_t st;
    logic [7:0] cmd;
    logic [3:0] rcnt;
    logic nomem_pend;
    logic busy;
    logic rsp_vld;
    logic [7:0] rsp_code;
    logic rsp_has_pin;
    logic [7:0] rsp_pin;
    logic net_up_msg;
    logic soft_rst;
    logic [NPIN-1:0] gpio;
    logic [7:0] ua_cfg;
    logic [23:0] ua_baud;
    logic [7:0] ub_cfg;
    logic [23:0] ub_baud;
    logic [7:0] spi_cfg;
    logic [7:0] spi_pin;
    logic [15:0] grp_cnt;
    logic [7:0] grp_fld;
    logic [15:0] grp_mem;
  } sch_state_t;

  sch_state_t st_ff;
  sch_state_t nxt_st;
  logic [63:0] args;
  logic [3:0] nargs;

  // ---------------------------------------------------------------
  // Argument collection.
  // ---------------------------------------------------------------
  sch_arg_buf u_args (
    .clk(clk),
    .clr(sys_rst | (cmd_start & (st_ff.st == ST_IDLE))),
    .byte_vld(arg_vld & (st_ff.st == ST_COLLECT)),
    .byte_in(arg_byte),
    .args(args),
    .count(nargs)
  );

  // groups from one, byte per eight.
  function automatic logic [15:0] grp_bytes(input logic [15:0] n);
    grp_bytes = 16'((17'(n) + 17'h7) >> 3);
  endfunction

  // Length check shared by all commands; 0 means length is fine.
  function automatic logic [7:0] len_chk(input logic [3:0] n, input logic [3:0] lo,
                                         input logic [3:0] hi);
    if (n < lo) begin
      len_chk = RSP_SHORT;
    end else if (n > hi) begin
      len_chk = RSP_LONG;
    end else begin
      len_chk = RSP_OK;
    end
  endfunction

  // ---------------------------------------------------------------
  // Command execution.
  // ---------------------------------------------------------------
  // Every decision is made at frame end, so one frame yields at most one answer.
  always_comb begin
    logic [7:0] code;
    logic [7:0] pin;
    logic has_pin;
    logic send;
    logic [3:0] lo;
    logic [3:0] hi;
    logic [7:0] cfg;
    logic [15:0] gc;
    code = RSP_OK;
    pin = 8'h00;
    has_pin = 1'b0;
    send = 1'b1;
    lo = LEN_CFG_ONLY;
    hi = LEN_CFG_ONLY;
    cfg = args[7:0];
    gc = args[15:0];
    nxt_st = st_ff;
    nxt_st.rsp_vld = 1'b0;
    nxt_st.net_up_msg = 1'b0;
    unique case (st_ff.st)
      ST_IDLE: begin
        nxt_st.busy = 1'b0;
        if (cmd_start) begin
          nxt_st.cmd = cmd_id;
          nxt_st.busy = 1'b1;
          nxt_st.st = ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (cmd_end) begin
          nxt_st.st = ST_IDLE;
          nxt_st.busy = 1'b0;
          case (st_ff.cmd)
            CMD_TOGGLE: begin
              lo = LEN_TOGGLE;
              hi = LEN_TOGGLE;
            end
            CMD_UART_A, CMD_UART_B: begin
              lo = cfg[EN_POS] ? LEN_UART : LEN_CFG_ONLY;
              hi = LEN_UART;
            end
            CMD_SPI: begin
              lo = cfg[EN_POS] ? LEN_SPI : LEN_CFG_ONLY;
              hi = LEN_SPI;
            end
            CMD_RESTORE: begin
              lo = LEN_RESTORE;
              hi = LEN_RESTORE;
            end
            CMD_MCAST: begin
              lo = LEN_MCAST;
              hi = LEN_MCAST;
            end
            default: begin
              send = 1'b0;
            end
          endcase
          if (nargs == 4'h0) begin
            code = RSP_SHORT;
          end else begin
            code = len_chk(nargs, lo, hi);
          end
          if (send && code == RSP_OK) begin
            case (st_ff.cmd)
              CMD_TOGGLE: begin
                pin = args[7:0];
                has_pin = 1'b1;
                if (pin >= 8'(NPIN) || !pin_is_gpio[pin[4:0]]) begin
                  code = RSP_NOT_GPIO;
                end else if (!pin_is_out[pin[4:0]]) begin
                  code = RSP_NOT_OUT;
                end else begin
                  has_pin = 1'b0;
                  nxt_st.gpio[pin[4:0]] = ~st_ff.gpio[pin[4:0]];
                end
              end
              CMD_UART_A, CMD_UART_B: begin
                pin = (st_ff.cmd == CMD_UART_A) ? uart_a_pin : uart_b_pin;
                if (cfg[EN_POS] && pin < 8'(NPIN) && pin_busy[pin[4:0]]) begin
                  code = RSP_IN_USE;
                  has_pin = 1'b1;
                end else if (st_ff.cmd == CMD_UART_A) begin
                  nxt_st.ua_cfg = cfg;
                  if (nargs == LEN_UART) begin
                    nxt_st.ua_baud = args[31:8];
                  end
                end else begin
                  nxt_st.ub_cfg = cfg;
                  if (nargs == LEN_UART) begin
                    nxt_st.ub_baud = args[31:8];
                  end
                end
              end
              CMD_SPI: begin
                pin = args[15:8];
                nxt_st.spi_cfg = cfg;
                if (cfg[EN_POS]) begin
                  if (pin >= 8'(NPIN) || !pin_is_gpio[pin[4:0]]) begin
                    code = RSP_NOT_GPIO;
                    has_pin = 1'b1;
                    nxt_st.spi_cfg = st_ff.spi_cfg;
                  end else if (pin_busy[pin[4:0]]) begin
                    code = RSP_IN_USE;
                    has_pin = 1'b1;
                    nxt_st.spi_cfg = st_ff.spi_cfg;
                  end else begin
                    nxt_st.spi_pin = pin;
                  end
                end
              end
              CMD_RESTORE: begin
                if (args[31:0] != RESTORE_KEY) begin
                  code = RSP_BADKEY;
                end else begin
                  send = 1'b0;
                  nxt_st = '0;
                  nxt_st.st = ST_RESET;
                  nxt_st.busy = 1'b1;
                  nxt_st.soft_rst = 1'b1;
                  nxt_st.rcnt = RESTORE_RST_CYC;
                  nxt_st.ua_baud = RST_BAUD;
                  nxt_st.ub_baud = RST_BAUD;
                  nxt_st.grp_fld = RST_GRP_FLD;
                end
              end
              CMD_MCAST: begin
                if (gc > GRP_MAX) begin
                  code = RSP_GRP_MAX;
                end else if (args[23:16] == 8'h00 || args[23:16] > GRP_FLD_MAX) begin
                  code = RSP_GRP_FLD;
                end else if (grp_bytes(gc) > mem_free_bytes) begin
                  send = 1'b0;
                  nxt_st.st = ST_RESET;
                  nxt_st.busy = 1'b1;
                  nxt_st.soft_rst = 1'b1;
                  nxt_st.rcnt = RESTORE_RST_CYC;
                  nxt_st.nomem_pend = 1'b1;
                end else begin
                  nxt_st.grp_cnt = gc;
                  nxt_st.grp_fld = args[23:16];
                  nxt_st.grp_mem = grp_bytes(gc);
                end
              end
              default: begin
                send = 1'b0;
              end
            endcase
          end
          if (code == RSP_OK && !ack_en) begin
            send = 1'b0;
          end
          nxt_st.rsp_vld = send;
          nxt_st.rsp_code = code;
          nxt_st.rsp_has_pin = send & has_pin;
          nxt_st.rsp_pin = pin;
        end
      end
      ST_RESET: begin
        nxt_st.rcnt = st_ff.rcnt - 4'h1;
        if (st_ff.rcnt == 4'h1) begin
          nxt_st.soft_rst = 1'b0;
          nxt_st.rsp_vld = 1'b1;
          nxt_st.rsp_code = st_ff.nomem_pend ? RSP_NOMEM : RSP_RESET;
          nxt_st.rsp_has_pin = 1'b0;
          nxt_st.st = st_ff.nomem_pend ? ST_IDLE : ST_WAIT_NET;
          nxt_st.busy = ~st_ff.nomem_pend;
          nxt_st.nomem_pend = 1'b0;
        end
      end
      ST_WAIT_NET: begin
        if (net_ready) begin
          nxt_st.net_up_msg = 1'b1;
          nxt_st.busy = 1'b0;
          nxt_st.st = ST_IDLE;
        end
      end
    endcase
  end

  // Register the whole state; reset loads factory defaults.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.st <= ST_IDLE;
      st_ff.ua_cfg <= RST_UART_CFG;
      st_ff.ub_cfg <= RST_UART_CFG;
      st_ff.ua_baud <= RST_BAUD;
      st_ff.ub_baud <= RST_BAUD;
      st_ff.grp_cnt <= RST_GRP_CNT;
      st_ff.grp_fld <= RST_GRP_FLD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs; config bytes carry raw.
  // ---------------------------------------------------------------
  assign busy = st_ff.busy;
  assign rsp_vld = st_ff.rsp_vld;
  assign rsp_code = st_ff.rsp_code;
  assign rsp_has_pin = st_ff.rsp_has_pin;
  assign rsp_pin = st_ff.rsp_pin;
  assign net_up_msg = st_ff.net_up_msg;
  assign soft_rst = st_ff.soft_rst;
  assign gpio_out = st_ff.gpio;
  assign uart_a_cfg = st_ff.ua_cfg;
  assign uart_a_baud = st_ff.ua_baud;
  assign uart_b_cfg = st_ff.ub_cfg;
  assign uart_b_baud = st_ff.ub_baud;
  assign spi_cfg = st_ff.spi_cfg;
  assign spi_pend_pin = st_ff.spi_pin;
  assign grp_count = st_ff.grp_cnt;
  assign grp_fields = st_ff.grp_fld;
  assign grp_mem_bytes = st_ff.grp_mem;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  sequence end_ok_s;
    st_ff.st == ST_COLLECT && cmd_end;
  endsequence

  restore_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    end_ok_s and st_ff.cmd == CMD_RESTORE && nargs == LEN_RESTORE && args[31:0] == RESTORE_KEY
    |=> soft_rst && !rsp_vld) else $error("restore did not reset");
  restore_key_a: assert property (@(posedge clk) disable iff (sys_rst)
    end_ok_s and st_ff.cmd == CMD_RESTORE && nargs == LEN_RESTORE && args[31:0] != RESTORE_KEY
    |=> rsp_vld && rsp_code == RSP_BADKEY) else $error("bad key not refused");
  reset_report_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(soft_rst) |-> rsp_vld && (rsp_code == RSP_RESET || rsp_code == RSP_NOMEM))
    else $error("no reset report");
  ack_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_vld && rsp_code == RSP_OK |-> $past(ack_en)) else $error("ack sent while off");
  too_long_a: assert property (@(posedge clk) disable iff (sys_rst)
    end_ok_s and st_ff.cmd == CMD_TOGGLE && nargs > LEN_TOGGLE
    |=> rsp_vld && rsp_code == RSP_LONG) else $error("long frame not refused");
  toggle_inv_a: assert property (@(posedge clk) disable iff (sys_rst)
    end_ok_s and st_ff.cmd == CMD_TOGGLE && nargs == LEN_TOGGLE && args[7:0] < 8'(NPIN)
    && pin_is_gpio[args[4:0]] && pin_is_out[args[4:0]]
    |=> gpio_out[$past(args[4:0])] != $past(gpio_out[args[4:0]])) else $error("no toggle");
  toggle_out_a: assert property (@(posedge clk) disable iff (sys_rst)
    end_ok_s and st_ff.cmd == CMD_TOGGLE && nargs == LEN_TOGGLE && args[7:0] < 8'(NPIN)
    && pin_is_gpio[args[4:0]] && !pin_is_out[args[4:0]]
    |=> rsp_vld && rsp_code == RSP_NOT_OUT && rsp_has_pin) else $error("code 22 missing");
  grp_max_a: assert property (@(posedge clk) disable iff (sys_rst)
    end_ok_s and st_ff.cmd == CMD_MCAST && nargs == LEN_MCAST && args[15:0] > GRP_MAX
    |=> rsp_vld && rsp_code == RSP_GRP_MAX) else $error("group max not refused");
  grp_mem_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(grp_count) && !soft_rst |-> grp_mem_bytes == grp_bytes(grp_count))
    else $error("group storage size wrong");
endmodule
`default_nettype wire

/* hw/sch_pkg.sv */
// Package with command codes, response codes, field positions and reset values.
package sch_pkg;
  // ---------------------------------------------------------------
  // Command identifiers seen on the command port.
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_TOGGLE = 8'h01;
  localparam logic [7:0] CMD_UART_A = 8'h02;
  localparam logic [7:0] CMD_UART_B = 8'h03;
  localparam logic [7:0] CMD_SPI = 8'h04;
  localparam logic [7:0] CMD_RESTORE = 8'h05;
  localparam logic [7:0] CMD_MCAST = 8'h06;
  // ---------------------------------------------------------------
  // Response codes.
  // ---------------------------------------------------------------
  localparam logic [7:0] RSP_OK = 8'h00;
  localparam logic [7:0] RSP_SHORT = 8'h01;
  localparam logic [7:0] RSP_LONG = 8'h02;
  localparam logic [7:0] RSP_RESET = 8'h03;
  localparam logic [7:0] RSP_NOMEM = 8'h05;
  localparam logic [7:0] RSP_BADKEY = 8'h07;
  localparam logic [7:0] RSP_NOT_GPIO = 8'h08;
  localparam logic [7:0] RSP_IN_USE = 8'h09;
  localparam logic [7:0] RSP_GRP_MAX = 8'h0A;
  localparam logic [7:0] RSP_GRP_FLD = 8'h0B;
  localparam logic [7:0] RSP_NOT_OUT = 8'h16;
  // ---------------------------------------------------------------
  // Configuration byte fields.
  // ---------------------------------------------------------------
  localparam int EN_POS = 0;
  localparam int PAR_LO = 1;
  localparam int STOP_POS = 3;
  localparam int FLOW_POS = 4;
  localparam int CPOL_POS = 1;
  localparam int CPHA_POS = 2;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // ---------------------------------------------------------------
  // Lengths, limits and reset values.
  // ---------------------------------------------------------------
  localparam logic [31:0] RESTORE_KEY = 32'hF85A23E1;
  localparam logic [3:0] LEN_TOGGLE = 4'h1;
  localparam logic [3:0] LEN_UART = 4'h4;
  localparam logic [3:0] LEN_SPI = 4'h2;
  localparam logic [3:0] LEN_RESTORE = 4'h4;
  localparam logic [3:0] LEN_MCAST = 4'h3;
  localparam logic [3:0] LEN_CFG_ONLY = 4'h1;
  localparam int NPIN = 32;
  localparam logic [15:0] GRP_MAX = 16'h0400;
  localparam logic [7:0] GRP_FLD_MAX = 8'h07;
  localparam logic [7:0] RST_UART_CFG = 8'h00;
  localparam logic [23:0] RST_BAUD = 24'h002580;
  localparam logic [15:0] RST_GRP_CNT = 16'h0000;
  localparam logic [7:0] RST_GRP_FLD = 8'h01;
  localparam int ARG_MAX = 8;
  // Reset pulse length after a factory restore, in cycles.
  localparam logic [3:0] RESTORE_RST_CYC = 4'h8;
endpackage

/* hw/sch_arg_buf.sv */
// Argument byte collector for one command frame.
`timescale 1ns/1ps
`default_nettype none
module sch_arg_buf
  import sch_pkg::*;
(
  input wire logic clk,
  input wire logic clr,
  input wire logic byte_vld,
  input wire logic [7:0] byte_in,
  output logic [63:0] args,
  output logic [3:0] count
);
  typedef struct packed {
    logic [63:0] args;
    logic [3:0] count;
  } sch_ab_t;
  sch_ab_t st_ff;
  sch_ab_t nxt_st;

  // ---------------------------------------------------------------
  // Byte capture.
  // ---------------------------------------------------------------
  // Bytes past the eighth are only counted, so an overlong frame is still reported.
  always_comb begin
    nxt_st = st_ff;
    if (clr) begin
      nxt_st = '0;
    end else if (byte_vld) begin
      if (st_ff.count < 4'(ARG_MAX)) begin
        nxt_st.args[st_ff.count[2:0]*8 +: 8] = byte_in;
      end
      if (st_ff.count != 4'hF) begin
        nxt_st.count = st_ff.count + 4'h1;
      end
    end
  end

  // Clear acts as reset, driven by the handler on frame start.
  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  assign args = st_ff.args;
  assign count = st_ff.count;
endmodule
`default_nettype wire

/* dv/sch_host_model.sv */
// Host controller model that issues command frames to the handler.
`timescale 1ns/1ps
`default_nettype none
module sch_host_model
  import sch_pkg::*;
(
  input wire logic clk,
  output logic cmd_start,
  output logic [7:0] cmd_id,
  output logic arg_vld,
  output logic [7:0] arg_byte,
  output logic cmd_end
);
  // ---------------------------------------------------------------
  // Frame driver
  // ---------------------------------------------------------------
  // All frame lines start idle before the first edge.
  initial begin
    cmd_start = 1'b0;
    cmd_id = 8'h00;
    arg_vld = 1'b0;
    arg_byte = 8'h00;
    cmd_end = 1'b0;
  end

  // Idle lines carry the inverse of the last value, so a stale byte never passes.
  // A nonzero gap stretches the frame the way a slow host would.
  // little-endian argument bytes
  task automatic send(input logic [7:0] id, input logic [63:0] args, input int n,
                      input int gap);
    @(negedge clk);
    cmd_start = 1'b1;
    cmd_id = id;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      cmd_start = 1'b0;
      cmd_id = ~id;
      arg_vld = 1'b1;
      arg_byte = args[8*i +: 8];
      repeat (gap) begin
        @(negedge clk);
        arg_vld = 1'b0;
        arg_byte = ~arg_byte;
      end
    end
    @(negedge clk);
    cmd_start = 1'b0;
    arg_vld = 1'b0;
    arg_byte = ~arg_byte;
    cmd_end = 1'b1;
    @(negedge clk);
    cmd_end = 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/sch_cmd_handler_bench.sv */
// Self-checking testbench for the command handler.
`timescale 1ns/1ps
`default_nettype none
module sch_cmd_handler_bench
  import sch_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ack_en = 1'b1;
  logic net_ready = 1'b0;
  logic [NPIN-1:0] pin_is_gpio = 32'h0000000F;
  logic [NPIN-1:0] pin_is_out = 32'h0000000B;
  logic [NPIN-1:0] pin_busy = 32'h00000000;
  logic [7:0] uart_a_pin = 8'h05;
  logic [7:0] uart_b_pin = 8'h06;
  logic [15:0] mem_free_bytes = 16'hFFFF;
  logic cmd_start, arg_vld, cmd_end, busy, rsp_vld, rsp_has_pin, net_up_msg, soft_rst;
  logic [7:0] cmd_id, arg_byte, rsp_code, rsp_pin, uart_a_cfg, uart_b_cfg, spi_cfg;
  logic [7:0] spi_pend_pin, grp_fields, got_code, got_pin;
  logic [NPIN-1:0] gpio_out;
  logic [23:0] uart_a_baud, uart_b_baud;
  logic [15:0] grp_count, grp_mem_bytes;
  logic got_hp;
  int n_errors = 0;
  int check_count = 0;
  int n_rsp = 0;
  int n_net = 0;

  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end

  sch_host_model u_host (.clk(clk), .cmd_start(cmd_start), .cmd_id(cmd_id),
    .arg_vld(arg_vld), .arg_byte(arg_byte), .cmd_end(cmd_end));

  sch_cmd_handler u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_start(cmd_start),
    .cmd_id(cmd_id), .arg_vld(arg_vld), .arg_byte(arg_byte), .cmd_end(cmd_end),
    .ack_en(ack_en), .pin_is_gpio(pin_is_gpio), .pin_is_out(pin_is_out),
    .pin_busy(pin_busy), .uart_a_pin(uart_a_pin), .uart_b_pin(uart_b_pin),
    .mem_free_bytes(mem_free_bytes), .net_ready(net_ready), .busy(busy),
    .rsp_vld(rsp_vld), .rsp_code(rsp_code), .rsp_has_pin(rsp_has_pin),
    .rsp_pin(rsp_pin), .net_up_msg(net_up_msg), .soft_rst(soft_rst),
    .gpio_out(gpio_out), .uart_a_cfg(uart_a_cfg), .uart_a_baud(uart_a_baud),
    .uart_b_cfg(uart_b_cfg), .uart_b_baud(uart_b_baud), .spi_cfg(spi_cfg),
    .spi_pend_pin(spi_pend_pin), .grp_count(grp_count), .grp_fields(grp_fields),
    .grp_mem_bytes(grp_mem_bytes));

  // Response monitor; pulses are caught at every rising edge, so no answer slips past a task.
  always @(posedge clk) begin
    if (rsp_vld === 1'b1) begin
      n_rsp <= n_rsp + 1;
      got_code <= rsp_code;
      got_hp <= rsp_has_pin;
      got_pin <= rsp_pin;
    end
    if (net_up_msg === 1'b1) begin
      n_net <= n_net + 1;
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for idle under a bound, then sends one frame and lets the answer land.
  task automatic do_cmd(input logic [7:0] id, input logic [63:0] a, input int n, input int gap);
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 50) begin
      @(negedge clk);
      t++;
    end
    chk("idle before frame", 32'h0, t / 50);
    n_rsp = 0;
    u_host.send(id, a, n, gap);
    repeat (3) @(negedge clk);
  endtask

  task automatic exp_rsp(input int cnt, input logic [7:0] code, input logic hp,
                         input logic [7:0] pin);
    chk("response count", cnt, n_rsp);
    if (cnt > 0) begin
      chk("rsp_code", code, got_code);
      chk("rsp_has_pin", hp, got_hp);
      if (hp) begin
        chk("rsp_pin", pin, got_pin);
      end
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_toggle();
    do_cmd(CMD_TOGGLE, 64'h3, 1, 0);
    exp_rsp(1, RSP_OK, 1'b0, 8'h00);
    chk("gpio_out", 32'h8, gpio_out);
    ack_en = 1'b0;
    do_cmd(CMD_TOGGLE, 64'h3, 1, 0);
    exp_rsp(0, RSP_OK, 1'b0, 8'h00);
    chk("gpio_out", 32'h0, gpio_out);
    do_cmd(CMD_TOGGLE, 64'h4, 1, 0);
    exp_rsp(1, RSP_NOT_GPIO, 1'b1, 8'h04);
    do_cmd(CMD_TOGGLE, 64'h2, 1, 0);
    exp_rsp(1, RSP_NOT_OUT, 1'b1, 8'h02);
    do_cmd(CMD_TOGGLE, 64'h0, 0, 0);
    exp_rsp(1, RSP_SHORT, 1'b0, 8'h00);
    do_cmd(CMD_TOGGLE, 64'h0303, 2, 0);
    exp_rsp(1, RSP_LONG, 1'b0, 8'h00);
    chk("gpio_out", 32'h0, gpio_out);
    ack_en = 1'b1;
    do_cmd(8'h07, 64'h3, 1, 0);
    exp_rsp(0, RSP_OK, 1'b0, 8'h00);
    chk("gpio_out", 32'h0, gpio_out);
  endtask

  task automatic t_uart();
    logic [7:0] id;
    logic [7:0] pn;
    for (int p = 0; p < 2; p++) begin
      id = p ? CMD_UART_B : CMD_UART_A;
      pn = p ? 8'h06 : 8'h05;
      do_cmd(id, 64'h01C2001D, 4, 0);
      exp_rsp(1, RSP_OK, 1'b0, 8'h00);
      chk("uart cfg", 32'h1D, p ? uart_b_cfg : uart_a_cfg);
      chk("parity", PAR_EVEN, ((p ? uart_b_cfg : uart_a_cfg) >> PAR_LO) & 8'h03);
      chk("uart baud", 32'h01C200, p ? uart_b_baud : uart_a_baud);
      do_cmd(id, 64'h004B0007, 4, 2);
      exp_rsp(1, RSP_OK, 1'b0, 8'h00);
      chk("uart cfg", 32'h07, p ? uart_b_cfg : uart_a_cfg);
      chk("parity", PAR_ODD, ((p ? uart_b_cfg : uart_a_cfg) >> PAR_LO) & 8'h03);
      chk("uart baud", 32'h004B00, p ? uart_b_baud : uart_a_baud);
      do_cmd(id, 64'h00, 1, 0);
      exp_rsp(1, RSP_OK, 1'b0, 8'h00);
      chk("uart cfg", 32'h00, p ? uart_b_cfg : uart_a_cfg);
      chk("parity", PAR_NONE, ((p ? uart_b_cfg : uart_a_cfg) >> PAR_LO) & 8'h03);
      do_cmd(id, 64'h4B0007, 3, 0);
      exp_rsp(1, RSP_SHORT, 1'b0, 8'h00);
      do_cmd(id, 64'h0001C2001D, 5, 0);
      exp_rsp(1, RSP_LONG, 1'b0, 8'h00);
      pin_busy = 32'h00000060;
      do_cmd(id, 64'h01C2001D, 4, 0);
      exp_rsp(1, RSP_IN_USE, 1'b1, pn);
      chk("uart cfg", 32'h00, p ? uart_b_cfg : uart_a_cfg);
      pin_busy = 32'h00000000;
    end
  endtask

  task automatic t_spi();
    do_cmd(CMD_SPI, 64'h0107, 2, 0);
    exp_rsp(1, RSP_OK, 1'b0, 8'h00);
    chk("spi_cfg", 32'h07, spi_cfg);
    chk("cpha cpol", 32'h3, {spi_cfg[CPHA_POS], spi_cfg[CPOL_POS]});
    chk("spi_pend_pin", 32'h01, spi_pend_pin);
    do_cmd(CMD_SPI, 64'h0203, 2, 1);
    chk("spi_cfg", 32'h03, spi_cfg);
    chk("cpha cpol", 32'h1, {spi_cfg[CPHA_POS], spi_cfg[CPOL_POS]});
    do_cmd(CMD_SPI, 64'h0205, 2, 0);
    exp_rsp(1, RSP_OK, 1'b0, 8'h00);
    chk("cpha cpol", 32'h2, {spi_cfg[CPHA_POS], spi_cfg[CPOL_POS]});
    chk("spi_pend_pin", 32'h02, spi_pend_pin);
    do_cmd(CMD_SPI, 64'h00, 1, 0);
    exp_rsp(1, RSP_OK, 1'b0, 8'h00);
    chk("spi_cfg", 32'h00, spi_cfg);
    do_cmd(CMD_SPI, 64'h0401, 2, 0);
    exp_rsp(1, RSP_NOT_GPIO, 1'b1, 8'h04);
    pin_busy = 32'h00000002;
    do_cmd(CMD_SPI, 64'h0101, 2, 0);
    exp_rsp(1, RSP_IN_USE, 1'b1, 8'h01);
    pin_busy = 32'h00000000;
    chk("spi_cfg", 32'h00, spi_cfg);
  endtask

  task automatic t_restore();
    do_cmd(CMD_TOGGLE, 64'h0, 1, 0);
    do_cmd(CMD_RESTORE, 64'hF85A23E0, 4, 0);
    exp_rsp(1, RSP_BADKEY, 1'b0, 8'h00);
    do_cmd(CMD_RESTORE, 64'h5A23E1, 3, 0);
    exp_rsp(1, RSP_SHORT, 1'b0, 8'h00);
    chk("gpio_out", 32'h1, gpio_out);
    do_cmd(CMD_RESTORE, 64'hF85A23E1, 4, 0);
    chk("soft_rst", 32'h1, soft_rst);
    chk("ack count", 32'h0, n_rsp);
    chk("gpio_out", 32'h0, gpio_out);
    chk("uart baud", RST_BAUD, uart_a_baud);
    chk("grp_fields", RST_GRP_FLD, grp_fields);
    repeat (12) @(negedge clk);
    exp_rsp(1, RSP_RESET, 1'b0, 8'h00);
    chk("net message early", 32'h0, n_net);
    net_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk("net message", 32'h1, n_net);
  endtask

  task automatic t_mcast();
    do_cmd(CMD_MCAST, 64'h030400, 3, 0);
    exp_rsp(1, RSP_OK, 1'b0, 8'h00);
    chk("grp_count", 32'h0400, grp_count);
    chk("grp_fields", 32'h03, grp_fields);
    chk("grp_mem_bytes", 32'h0080, grp_mem_bytes);
    do_cmd(CMD_MCAST, 64'h070008, 3, 0);
    chk("grp_mem_bytes", 32'h0001, grp_mem_bytes);
    do_cmd(CMD_MCAST, 64'h010401, 3, 0);
    exp_rsp(1, RSP_GRP_MAX, 1'b0, 8'h00);
    do_cmd(CMD_MCAST, 64'h000008, 3, 0);
    exp_rsp(1, RSP_GRP_FLD, 1'b0, 8'h00);
    do_cmd(CMD_MCAST, 64'h080008, 3, 0);
    exp_rsp(1, RSP_GRP_FLD, 1'b0, 8'h00);
    do_cmd(CMD_MCAST, 64'h0400, 2, 0);
    exp_rsp(1, RSP_SHORT, 1'b0, 8'h00);
    mem_free_bytes = 16'h0010;
    do_cmd(CMD_MCAST, 64'h010400, 3, 0);
    repeat (12) @(negedge clk);
    exp_rsp(1, RSP_NOMEM, 1'b0, 8'h00);
    chk("grp_count", 32'h0008, grp_count);
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles; this bound leaves ample slack.
  initial begin
    #(40 * 5000);
    n_errors++;
    finish_test();
  end

  // Main sequence, driven on falling edges.
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    chk("baud reset", RST_BAUD, uart_b_baud);
    t_toggle();
    t_uart();
    t_spi();
    t_restore();
    t_mcast();
    finish_test();
  end
endmodule
`default_nettype wire
